// ===== rtl/gauge_spi_control.sv
`timescale 1ns/10ps
`include "gauge_spi_cfg.svh"
module gauge_spi_control
   import gauge_spi_pkg::*;
#(
   parameter int CAL_COUNT_W = 10,
   parameter int TRIM_W      = 8
) (
   // clock and reset
   input  wire logic        clock_i,
   input  wire logic        reset_n_i,
   // serial pins
   input  wire logic        cs_n_i,
   input  wire logic        sclk_i,
   input  wire logic        si_i,
   output logic             so_o,
   output logic             so_oe_o,
   // state reported by the motion core
   input  wire logic        gauge0_moving_i,
   input  wire logic        gauge1_moving_i,
   input  wire logic [15:0] device_status_i,
   input  wire logic [15:0] rtz_accum_i,
   input  wire logic [11:0] gauge0_position_i,
   input  wire logic [11:0] gauge1_position_i,
   input  wire logic [7:0]  gauge0_velocity_step_i,
   input  wire logic [7:0]  gauge1_velocity_step_i,
   // microstep dwell timer
   input  wire logic        step_start_i,
   input  wire logic [3:0]  ramp_index_i,
   output logic             step_done_o,
   // configuration to the motion core
   output logic [1:0]       gauge_enable_o,
   output logic             standby_o,
   output logic             emulation_disable_o,
   output logic [1:0]       position_zero_cw_o,
   output logic [7:0]       max_velocity0_o,
   output logic [7:0]       max_velocity1_o,
   output logic [11:0]      target_position0_o,
   output logic [11:0]      target_position1_o,
   output logic [1:0]       target_write_o,
   output logic [12:0]      rtz_command_o,
   output logic             rtz_command_write_o,
   output logic [12:0]      rtz_setup_o,
   output logic             internal_tick_o,
   output logic             cal_fault_o
);
   localparam int NOMINAL_TICK_NS     = 1000000 / `GS_INT_CLK_KHZ;
   localparam int NOMINAL_TICK_CYCLES = NOMINAL_TICK_NS / `GS_CLK_PERIOD_NS;
   localparam int CAL_TICKS           = (`GS_CAL_PULSE_NS * `GS_INT_CLK_KHZ) / 1000000;
   localparam logic [CAL_COUNT_W-1:0] CAL_COUNT_MAX = '1;

   if (CAL_COUNT_W < 4 || TRIM_W < 4 || NOMINAL_TICK_CYCLES >= 2**TRIM_W
       || (2**CAL_COUNT_W) / CAL_TICKS >= 2**TRIM_W) begin : g_bad_params
      $error("gauge_spi_control: CAL_COUNT_W or TRIM_W out of range");
   end

   logic [2:0]    pins_s;
   logic          cs_n_s;
   logic          sclk_s;
   logic          si_s;
   logic          cs_n_prev_reg;
   logic          sclk_prev_reg;
   spi_word_type  in_shift_reg;
   spi_word_type  status_shift_reg;
   spi_word_type  status_word;
   logic [3:0]    fall_cnt_reg;
   logic          word_seen_reg;
   logic [4:0]    rise_cnt_reg;
   logic          so_reg;
   logic [2:0]    word_addr;
   logic          cs_fall;
   logic          cs_rise;
   logic          sclk_fall;
   logic          sclk_rise;
   logic          word_write;
   logic          cfg_write;
   logic [1:0]    gauge_enable_reg;
   logic          oscillator_slow_reg;
   logic          cal_freq_sel_reg;
   logic          emulation_disable_reg;
   logic [1:0]    position_zero_cw_reg;
   logic          gauge_select_reg;
   logic          speed_sel_reg;
   logic          pointer_sel_reg;
   logic          status_source_reg;
   cal_state_type cal_state_reg;
   logic [CAL_COUNT_W-1:0] cal_cnt_reg;
   logic          cal_over_reg;
   logic          cal_fault_reg;
   logic [1:0]    prescale_reg;
   logic          count_en;
   logic          cal_allowed;
   logic [CAL_COUNT_W:0] cal_sum;
   logic [TRIM_W-1:0] trim_calc;
   logic [TRIM_W-1:0] trim_reg;
   logic [TRIM_W:0]   tick_period;
   logic [TRIM_W:0]   tick_cnt_reg;
   logic          tick_reg;
   logic [7:0]    dwell_cnt_reg;
   logic          step_done_reg;

   pin_sync #(
      .WIDTH       (3),
      .RESET_VALUE (3'h4)
   ) u_pin_sync (
      .clock_i   (clock_i),
      .reset_n_i (reset_n_i),
      .async_i   ({cs_n_i, sclk_i, si_i}),
      .sync_o    (pins_s)
   );

   assign cs_n_s = pins_s[2];
   assign sclk_s = pins_s[1];
   assign si_s   = pins_s[0];

   always_ff @(posedge clock_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         cs_n_prev_reg <= 1'h1;
         sclk_prev_reg <= 1'h0;
      end else begin
         cs_n_prev_reg <= cs_n_s;
         sclk_prev_reg <= sclk_s;
      end
   end

   // clock edges only count while selected
   assign cs_fall   = cs_n_prev_reg & ~cs_n_s;
   assign cs_rise   = ~cs_n_prev_reg & cs_n_s;
   assign sclk_fall = ~cs_n_s & sclk_prev_reg & ~sclk_s;
   assign sclk_rise = ~cs_n_s & ~sclk_prev_reg & sclk_s;

   always_ff @(posedge clock_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         in_shift_reg <= '0;
      end else if (sclk_fall) begin
         in_shift_reg <= {in_shift_reg[14:0], si_s};
      end
   end

   always_ff @(posedge clock_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         fall_cnt_reg  <= 4'h0;
         word_seen_reg <= 1'h0;
      end else if (cs_fall) begin
         fall_cnt_reg  <= 4'h0;
         word_seen_reg <= 1'h0;
      end else if (sclk_fall) begin
         fall_cnt_reg <= fall_cnt_reg + 4'h1;
         if (fall_cnt_reg == 4'hf) begin
            word_seen_reg <= 1'h1;
         end
      end
   end

   // whole words only; last word shifted in is the one kept
   assign word_write = cs_rise & word_seen_reg & (fall_cnt_reg == 4'h0);
   assign word_addr  = in_shift_reg[`GS_ADDR_MSB:`GS_ADDR_LSB];
   assign cfg_write  = word_write & (word_addr == `GS_ADDR_CONFIG)
                       & ~in_shift_reg[`GS_CFG_NULL_CMD];

   always_comb begin
      status_word = device_status_i;
      status_word[`GS_STAT_CAL_FAULT] = cal_fault_reg;
      if (status_source_reg) begin
         if (!pointer_sel_reg) begin
            status_word = rtz_accum_i;
         end else if (!speed_sel_reg) begin
            status_word = {4'h0, gauge_select_reg ? gauge1_position_i : gauge0_position_i};
         end else begin
            status_word = {gauge1_velocity_step_i, gauge0_velocity_step_i};
         end
      end
   end

   always_ff @(posedge clock_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         rise_cnt_reg     <= 5'h0;
         status_shift_reg <= '0;
         so_reg           <= 1'h0;
      end else if (cs_fall) begin
         rise_cnt_reg <= 5'h0;
      end else if (sclk_rise) begin
         if (rise_cnt_reg == 5'h0) begin
            so_reg           <= status_word[15];
            status_shift_reg <= {status_word[14:0], 1'h0};
         end else if (rise_cnt_reg < 5'h10) begin
            so_reg           <= status_shift_reg[15];
            status_shift_reg <= {status_shift_reg[14:0], 1'h0};
         end else begin
            so_reg <= in_shift_reg[15];
         end
         if (rise_cnt_reg != 5'h10) begin
            rise_cnt_reg <= rise_cnt_reg + 5'h1;
         end
      end
   end

   assign so_o    = so_reg;
   assign so_oe_o = ~cs_n_s;

   // unused and test codes fall through every decode below
   always_ff @(posedge clock_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         gauge_enable_reg      <= `GS_RST_ENABLES;
         oscillator_slow_reg   <= `GS_RST_FLAG;
         cal_freq_sel_reg      <= `GS_RST_FLAG;
         emulation_disable_reg <= `GS_RST_FLAG;
         position_zero_cw_reg  <= `GS_RST_POS0_CW;
         gauge_select_reg      <= `GS_RST_FLAG;
         speed_sel_reg         <= `GS_RST_FLAG;
         pointer_sel_reg       <= `GS_RST_FLAG;
         status_source_reg     <= `GS_RST_FLAG;
      end else if (cfg_write) begin
         gauge_enable_reg[0]   <= in_shift_reg[`GS_CFG_G0_EN];
         gauge_enable_reg[1]   <= in_shift_reg[`GS_CFG_G1_EN];
         oscillator_slow_reg   <= in_shift_reg[`GS_CFG_OSC_SLOW];
         cal_freq_sel_reg      <= in_shift_reg[`GS_CFG_FREQ_SEL];
         emulation_disable_reg <= in_shift_reg[`GS_CFG_EMU_DIS];
         position_zero_cw_reg[in_shift_reg[`GS_CFG_GAUGE_SEL]]
            <= in_shift_reg[`GS_CFG_POS0_CW];
         gauge_select_reg      <= in_shift_reg[`GS_CFG_GAUGE_SEL];
         speed_sel_reg         <= in_shift_reg[`GS_CFG_SPEED_SEL];
         pointer_sel_reg       <= in_shift_reg[`GS_CFG_PTR_SEL];
         status_source_reg     <= in_shift_reg[`GS_CFG_STAT_SRC];
      end
   end

   always_ff @(posedge clock_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         max_velocity0_o     <= `GS_RST_MAX_VEL;
         max_velocity1_o     <= `GS_RST_MAX_VEL;
         target_position0_o  <= `GS_RST_POS;
         target_position1_o  <= `GS_RST_POS;
         rtz_command_o       <= `GS_RST_RTZ;
         rtz_setup_o         <= `GS_RST_RTZ;
         target_write_o      <= 2'h0;
         rtz_command_write_o <= 1'h0;
      end else begin
         target_write_o      <= 2'h0;
         rtz_command_write_o <= 1'h0;
         if (word_write) begin
            case (word_addr)
               `GS_ADDR_MAX_VEL: begin
                  if (in_shift_reg[`GS_VEL_G0]) begin
                     max_velocity0_o <= in_shift_reg[`GS_VEL_MSB:0];
                  end
                  if (in_shift_reg[`GS_VEL_G1]) begin
                     max_velocity1_o <= in_shift_reg[`GS_VEL_MSB:0];
                  end
               end
               `GS_ADDR_TARGET0: begin
                  target_position0_o <= in_shift_reg[`GS_POS_MSB:0];
                  target_write_o[0]  <= 1'h1;
               end
               `GS_ADDR_TARGET1: begin
                  target_position1_o <= in_shift_reg[`GS_POS_MSB:0];
                  target_write_o[1]  <= 1'h1;
               end
               `GS_ADDR_RTZ_CMD: begin
                  rtz_command_o       <= in_shift_reg[`GS_RTZ_MSB:0];
                  rtz_command_write_o <= 1'h1;
               end
               `GS_ADDR_RTZ_SETUP: begin
                  rtz_setup_o <= in_shift_reg[`GS_RTZ_MSB:0];
               end
               default: begin
               end
            endcase
         end
      end
   end

   assign gauge_enable_o      = gauge_enable_reg;
   assign standby_o           = (gauge_enable_reg == 2'h0);
   assign emulation_disable_o = emulation_disable_reg;
   assign position_zero_cw_o  = position_zero_cw_reg;
   assign cal_fault_o         = cal_fault_reg;

   // slow mode counts two cycles of three so the same trim covers a longer pulse
   always_ff @(posedge clock_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         prescale_reg <= 2'h0;
      end else begin
         prescale_reg <= (prescale_reg == 2'h2) ? 2'h0 : prescale_reg + 2'h1;
      end
   end

   assign count_en    = ~oscillator_slow_reg | (prescale_reg != 2'h2);
   assign cal_allowed = (gauge_enable_reg == 2'h0)
                        | (~gauge0_moving_i & ~gauge1_moving_i);
   assign cal_sum     = {1'h0, cal_cnt_reg}
                        + (cal_freq_sel_reg ? '0 : (CAL_COUNT_W+1)'(CAL_TICKS));
   assign trim_calc   = TRIM_W'(cal_sum / (CAL_COUNT_W+1)'(CAL_TICKS));

   always_ff @(posedge clock_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         cal_state_reg <= CAL_IDLE;
         cal_cnt_reg   <= '0;
         cal_over_reg  <= 1'h0;
         cal_fault_reg <= 1'h0;
         trim_reg      <= TRIM_W'(NOMINAL_TICK_CYCLES);
      end else begin
         unique case (cal_state_reg)
            CAL_IDLE: begin
               if (cfg_write && in_shift_reg[`GS_CFG_CAL_EN] && cal_allowed) begin
                  cal_state_reg <= CAL_ARMED;
               end
            end
            CAL_ARMED: begin
               if (cs_fall) begin
                  cal_state_reg <= CAL_TIMING;
                  cal_cnt_reg   <= '0;
                  cal_over_reg  <= 1'h0;
               end
            end
            CAL_TIMING: begin
               if (cs_rise) begin
                  cal_state_reg <= CAL_IDLE;
                  if (cal_over_reg || trim_calc == '0) begin
                     cal_fault_reg <= 1'h1;
                  end else begin
                     cal_fault_reg <= 1'h0;
                     trim_reg      <= trim_calc;
                  end
               end else if (count_en) begin
                  if (cal_cnt_reg == CAL_COUNT_MAX) begin
                     cal_over_reg <= 1'h1;
                  end else begin
                     cal_cnt_reg <= cal_cnt_reg + 1'h1;
                  end
               end
            end
         endcase
      end
   end

   // internal clock tick runs in standby as well
   assign tick_period = oscillator_slow_reg
                        ? {1'h0, trim_reg} + {2'h0, trim_reg[TRIM_W-1:1]}
                        : {1'h0, trim_reg};

   always_ff @(posedge clock_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         tick_cnt_reg <= '0;
         tick_reg     <= 1'h0;
      end else if (tick_cnt_reg + 1'h1 >= tick_period) begin
         tick_cnt_reg <= '0;
         tick_reg     <= 1'h1;
      end else begin
         tick_cnt_reg <= tick_cnt_reg + 1'h1;
         tick_reg     <= 1'h0;
      end
   end

   assign internal_tick_o = tick_reg;

   function automatic logic [7:0] step_time(input logic [3:0] index);
      case (index)
         4'h0:    step_time = 8'h40;
         4'h1:    step_time = 8'h30;
         4'h2:    step_time = 8'h28;
         4'h3:    step_time = 8'h20;
         4'h4:    step_time = 8'h1c;
         4'h5:    step_time = 8'h18;
         4'h6:    step_time = 8'h15;
         4'h7:    step_time = 8'h12;
         4'h8:    step_time = 8'h10;
         4'h9:    step_time = 8'h0e;
         4'ha:    step_time = 8'h0d;
         4'hb:    step_time = 8'h0c;
         4'hc:    step_time = 8'h0b;
         4'hd:    step_time = 8'h0a;
         4'he:    step_time = 8'h09;
         default: step_time = 8'h08;
      endcase
   endfunction : step_time

   always_ff @(posedge clock_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         dwell_cnt_reg <= 8'h00;
         step_done_reg <= 1'h0;
      end else begin
         step_done_reg <= 1'h0;
         if (step_start_i) begin
            dwell_cnt_reg <= step_time(ramp_index_i);
         end else if (tick_reg && dwell_cnt_reg != 8'h00) begin
            dwell_cnt_reg <= dwell_cnt_reg - 8'h01;
            step_done_reg <= (dwell_cnt_reg == 8'h01);
         end
      end
   end

   assign step_done_o = step_done_reg;

   default clocking cb @(posedge clock_i); endclocking
   default disable iff (!reset_n_i);

   sequence s_cal_request;
      cal_state_reg == CAL_IDLE && cfg_write && in_shift_reg[`GS_CFG_CAL_EN];
   endsequence
   sequence s_cal_end_overrun;
      cal_state_reg == CAL_TIMING && cal_over_reg && cs_rise;
   endsequence

   a_shift_in_fall: assert property (sclk_fall |=>
      in_shift_reg == {$past(in_shift_reg[14:0]), $past(si_s)})
      else $error("input shift missed a falling edge");
   a_short_dropped: assert property (cs_rise && fall_cnt_reg != 4'h0 |=>
      $stable(gauge_enable_reg) && $stable(target_position0_o) && !target_write_o[0])
      else $error("partial transfer changed a register");
   a_enable_latch: assert property (cfg_write |=>
      gauge_enable_reg == $past(in_shift_reg[1:0]))
      else $error("gauge enables not taken from the word");
   a_null_ignored: assert property (word_write && word_addr == `GS_ADDR_CONFIG
      && in_shift_reg[`GS_CFG_NULL_CMD] |=> $stable(status_source_reg)
      && $stable(gauge_enable_reg) && cal_state_reg == $past(cal_state_reg))
      else $error("null command changed configuration");
   a_unused_quiet: assert property (word_write && word_addr[2:1] == 2'h3 |=>
      $stable(rtz_setup_o) && $stable(gauge_enable_reg) && target_write_o == 2'h0)
      else $error("unused address changed state");
   a_status_first: assert property (sclk_rise && rise_cnt_reg == 5'h0 |=>
      so_o == $past(status_word[15]) ##0 so_oe_o)
      else $error("first output bit is not status msb");
   a_fifo_out: assert property (sclk_rise && rise_cnt_reg == 5'h10 |=>
      so_o == $past(in_shift_reg[15]))
      else $error("daisy bit not taken from input register");
   a_so_released: assert property (cs_n_s |-> !so_oe_o)
      else $error("output enabled while deselected");
   a_cal_refused: assert property (s_cal_request ##0 !cal_allowed |=>
      cal_state_reg == CAL_IDLE)
      else $error("calibration armed while a pointer moves");
   a_cal_fault_set: assert property (s_cal_end_overrun |=>
      cal_fault_o && (status_source_reg || status_word[`GS_STAT_CAL_FAULT]))
      else $error("overrun did not raise calibration fault");
   a_step_dwell: assert property (step_start_i && ramp_index_i == 4'hf |=>
      dwell_cnt_reg == 8'h08)
      else $error("dwell not loaded from step table");

endmodule : gauge_spi_control

// ===== common/gauge_spi_cfg.svh
`ifndef GAUGE_SPI_CFG_SVH
`define GAUGE_SPI_CFG_SVH

// word layout
`define GS_WORD_BITS        16
`define GS_ADDR_MSB         15
`define GS_ADDR_LSB         13

// address codes
`define GS_ADDR_CONFIG      3'h0
`define GS_ADDR_MAX_VEL     3'h1
`define GS_ADDR_TARGET0     3'h2
`define GS_ADDR_TARGET1     3'h3
`define GS_ADDR_RTZ_CMD     3'h4
`define GS_ADDR_RTZ_SETUP   3'h5
`define GS_ADDR_UNUSED      3'h6
`define GS_ADDR_TEST        3'h7

// power_enable_config fields
`define GS_CFG_G0_EN        0
`define GS_CFG_G1_EN        1
`define GS_CFG_OSC_SLOW     2
`define GS_CFG_CAL_EN       3
`define GS_CFG_FREQ_SEL     4
`define GS_CFG_EMU_DIS      5
`define GS_CFG_POS0_CW      7
`define GS_CFG_GAUGE_SEL    8
`define GS_CFG_SPEED_SEL    9
`define GS_CFG_PTR_SEL      10
`define GS_CFG_STAT_SRC     11
`define GS_CFG_NULL_CMD     12

// max_velocity fields
`define GS_VEL_MSB          7
`define GS_VEL_G0           8
`define GS_VEL_G1           9

// target position and rtz fields
`define GS_POS_MSB          11
`define GS_RTZ_MSB          12

// device status bit carrying the calibration fault
`define GS_STAT_CAL_FAULT   0

// reset values
`define GS_RST_ENABLES      2'h0
`define GS_RST_FLAG         1'h0
`define GS_RST_POS0_CW      2'h0
`define GS_RST_MAX_VEL      8'he1
`define GS_RST_POS          12'h000
`define GS_RST_RTZ          13'h0000

// timing
`define GS_CLK_PERIOD_NS    10
`define GS_INT_CLK_KHZ      1000
`define GS_CAL_PULSE_NS     8000

`endif

// ===== common/gauge_spi_pkg.sv
package gauge_spi_pkg;

   typedef enum logic [1:0] {
      CAL_IDLE,
      CAL_ARMED,
      CAL_TIMING
   } cal_state_type;

   typedef logic [15:0] spi_word_type;

endpackage : gauge_spi_pkg

// ===== rtl/pin_sync.sv
`timescale 1ns/10ps
module pin_sync #(
   parameter int               WIDTH       = 1,
   parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
   // clock and reset
   input  wire logic             clock_i,
   input  wire logic             reset_n_i,
   // pins
   input  wire logic [WIDTH-1:0] async_i,
   output logic      [WIDTH-1:0] sync_o
);
   logic [WIDTH-1:0] meta_reg;

   always_ff @(posedge clock_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         meta_reg <= RESET_VALUE;
         sync_o   <= RESET_VALUE;
      end else begin
         meta_reg <= async_i;
         sync_o   <= meta_reg;
      end
   end
endmodule : pin_sync

// ===== dv/spi_master_model.sv
`timescale 1ns/10ps
module spi_master_model (
   // serial pins
   output logic      cs_n_o,
   output logic      sclk_o,
   output logic      si_o,
   input  wire logic so_i
);
   initial begin
      cs_n_o = 1'b1;
      sclk_o = 1'b0;
      si_o   = 1'b0;
   end
   // one frame, msb first; sclk rests low outside frames
   task automatic xfer(input logic [31:0] tx, input int nbits, output logic [15:0] rx);
      rx     = '0;
      cs_n_o = 1'b0;
      #40;
      for (int i = nbits - 1; i >= 0; i--) begin
         sclk_o = 1'b1;
         si_o   = tx[i];
         #40;
         sclk_o = 1'b0;
         #40;
         rx = {rx[14:0], so_i};
      end
      cs_n_o = 1'b1;
      si_o   = ~si_o;
      #200;
   endtask : xfer
   // calibration reference: only select moves, clock and data hold still
   task automatic cal_pulse(input int low_ns);
      cs_n_o = 1'b0;
      #(low_ns);
      cs_n_o = 1'b1;
      #200;
   endtask : cal_pulse
endmodule : spi_master_model

// ===== dv/gauge_spi_control_tb_top.sv
`timescale 1ns/10ps
module gauge_spi_control_tb_top;
   logic        clock_i    = 1'b0;
   logic        reset_n_i  = 1'b0;
   logic        step_start = 1'b0;
   logic [15:0] status     = 16'ha5c2;
   logic [11:0] pos1       = 12'h3a7;
   logic        cs_n;
   logic        sclk;
   logic        si;
   logic        so;
   logic        standby;
   logic        emu_dis;
   logic        step_done;
   logic [1:0]  enables;
   logic [1:0]  pos_zero;
   logic [7:0]  vel0;
   logic [7:0]  vel1;
   logic [11:0] tpos0;
   logic [11:0] tpos1;
   logic [15:0] rx;
   logic [12:0] rtz_cmd;
   logic [12:0] rtz_setup;
   logic [1:0]  moving     = 2'h0;
   logic        so_oe;
   logic        cal_fault;
   int          err_total    = 0;
   int          total_checks = 0;
   int          n;

   always #5 clock_i = ~clock_i;

   spi_master_model m (.cs_n_o(cs_n), .sclk_o(sclk), .si_o(si), .so_i(so));

   gauge_spi_control dut (
      .clock_i(clock_i), .reset_n_i(reset_n_i), .cs_n_i(cs_n), .sclk_i(sclk), .si_i(si),
      .so_o(so), .so_oe_o(so_oe), .gauge0_moving_i(moving[0]), .gauge1_moving_i(moving[1]),
      .device_status_i(status), .rtz_accum_i(16'h0f0f), .gauge0_position_i(12'h155),
      .gauge1_position_i(pos1), .gauge0_velocity_step_i(8'h11), .gauge1_velocity_step_i(8'h22),
      .step_start_i(step_start), .ramp_index_i(4'hf), .step_done_o(step_done),
      .gauge_enable_o(enables), .standby_o(standby), .emulation_disable_o(emu_dis),
      .position_zero_cw_o(pos_zero), .max_velocity0_o(vel0), .max_velocity1_o(vel1),
      .target_position0_o(tpos0), .target_position1_o(tpos1), .target_write_o(),
      .rtz_command_o(rtz_cmd), .rtz_command_write_o(), .rtz_setup_o(rtz_setup),
      .internal_tick_o(), .cal_fault_o(cal_fault));

   task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
      total_checks++;
      if (got !== exp) begin
         err_total++;
         $display("mismatch %s expected %h seen %h", name, exp, got);
      end
   endtask : chk

   task automatic test_done;
      $display("checks %0d mismatches %0d", total_checks, err_total);
      if (err_total == 0 && total_checks > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask : test_done

   initial begin
      #200000;
      err_total++;
      test_done;
   end

   initial begin
      repeat (16) @(negedge clock_i);
      reset_n_i = 1'b1;
      repeat (4) @(negedge clock_i);
      chk("standby", 16'h1, 16'(standby));
      chk("so_oe", 16'h0, 16'(so_oe));
      m.xfer(32'h0003, 16, rx);
      chk("status", 16'ha5c2, rx);
      chk("enables", 16'h3, 16'(enables));
      chk("standby", 16'h0, 16'(standby));
      m.xfer(32'h213c, 16, rx);
      chk("vel0", 16'h3c, 16'(vel0));
      chk("vel1", 16'he1, 16'(vel1));
      m.xfer(32'h4123, 16, rx);
      chk("tpos0", 16'h123, 16'(tpos0));
      m.xfer(32'h00fc, 8, rx);
      chk("enables", 16'h3, 16'(enables));
      m.xfer({16'h4456, 16'h6abc}, 32, rx);
      chk("daisy", 16'h4456, rx);
      chk("tpos1", 16'habc, 16'(tpos1));
      chk("tpos0", 16'h123, 16'(tpos0));
      m.xfer(32'hc000, 16, rx);
      m.xfer(32'he000, 16, rx);
      m.xfer(32'h1000, 16, rx);
      chk("enables", 16'h3, 16'(enables));
      chk("tpos1", 16'habc, 16'(tpos1));
      m.xfer(32'h0da3, 16, rx);
      chk("pos_zero", 16'h2, 16'(pos_zero));
      chk("emu_dis", 16'h1, 16'(emu_dis));
      m.xfer(32'h1000, 16, rx);
      chk("position", {4'h0, pos1}, rx);
      m.xfer(32'h8abc, 16, rx);
      chk("rtz_cmd", 16'h0abc, 16'(rtz_cmd));
      m.xfer(32'hb123, 16, rx);
      chk("rtz_setup", 16'h1123, 16'(rtz_setup));
      @(negedge clock_i);
      step_start = 1'b1;
      @(negedge clock_i);
      step_start = 1'b0;
      for (n = 0; n < 2000 && step_done !== 1'b1; n++) @(negedge clock_i);
      chk("dwell", 16'h1, 16'(n >= 699 && n <= 802));
      m.xfer(32'h001b, 16, rx);
      m.cal_pulse(12000);
      chk("cal_fault", 16'h1, 16'(cal_fault));
      m.xfer(32'h1000, 16, rx);
      chk("fault_status", 16'ha5c3, rx);
      moving = 2'h1;
      m.xfer(32'h001b, 16, rx);
      m.cal_pulse(8000);
      chk("cal_refused", 16'h1, 16'(cal_fault));
      moving = 2'h0;
      m.xfer(32'h001b, 16, rx);
      m.cal_pulse(8000);
      chk("cal_good", 16'h0, 16'(cal_fault));
      test_done;
   end
endmodule : gauge_spi_control_tb_top
